//--- hdl/rvm_channel.sv
// One monitor channel (1 or 2): filter, flags, interrupt, event and reset timing.
// Assumes the comparator and low-speed oscillator inputs are already synchronised.
`timescale 1ns/1ps
`default_nettype none
module rvm_channel (
  input  wire logic                    i_clk,
  input  wire logic                    i_resetn,
  input  wire logic                    i_cmp_above,
  input  wire logic                    i_lsclk_tick,
  input  wire logic                    i_clr_crossing,
  input  wire rvm_pkg::rvm_chan_cfg_s  i_cfg,
  output rvm_pkg::rvm_chan_stat_s      o_stat
);
  import rvm_pkg::*;

  logic [4:0]        div_reg;
  logic              sample_tick;
  logic [1:0]        filt_reg;
  logic              level_reg;
  logic              level_next;
  logic              cross_reg;
  logic              irq_reg;
  logic              event_reg;
  logic              rst_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic              fall;
  logic              rise;
  logic              hit;

  function automatic logic [4:0] div_mask(input rvm_div_e d);
    case (d)
      RVM_DIV2: div_mask = 5'h03;
      RVM_DIV4: div_mask = 5'h07;
      RVM_DIV8: div_mask = 5'h0f;
      default:  div_mask = 5'h1f;
    endcase
  endfunction

  // --------------------------------------------------------------
  // Digital filter
  // --------------------------------------------------------------
  // Sample every 2n low-speed ticks; two equal samples are needed
  assign sample_tick = i_lsclk_tick && ((div_reg & div_mask(i_cfg.filter_div)) == 5'h00); // R6

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_reg <= DIV_RESET;
    end else if (i_lsclk_tick) begin
      div_reg <= div_reg + 5'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      filt_reg <= 2'h3;
    end else if (sample_tick) begin
      filt_reg <= {filt_reg[0], i_cmp_above};
    end
  end

  always_comb begin
    level_next = level_reg;
    if (!i_cfg.filter_en) begin
      level_next = i_cmp_above;
    end else if (filt_reg[1] == filt_reg[0]) begin
      level_next = filt_reg[0]; // R6
    end
  end

  // --------------------------------------------------------------
  // Flags, interrupt and event
  // --------------------------------------------------------------
  assign fall = i_cfg.enable && level_reg && !level_next;
  assign rise = i_cfg.enable && !level_reg && level_next;
  assign hit  = (i_cfg.irq_edge == RVM_IRQ_FALL) ? fall :
                (i_cfg.irq_edge == RVM_IRQ_RISE) ? rise : (fall || rise);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      level_reg <= 1'b1;
    end else begin
      level_reg <= level_next; // R7
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cross_reg <= 1'b0;
    end else if (fall || rise) begin
      cross_reg <= 1'b1; // R7
    end else if (i_clr_crossing) begin
      cross_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_reg   <= 1'b0;
      event_reg <= 1'b0;
    end else begin
      irq_reg   <= i_cfg.irq_en && hit; // R5
      event_reg <= fall || rise; // R10
    end
  end

  // --------------------------------------------------------------
  // Reset request and release timing
  // --------------------------------------------------------------
  // Recovery mode restarts the delay whenever the level is low again;
  // drop mode runs the delay once from the falling crossing.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_reg <= 1'b0;
      cnt_reg <= '0;
    end else if (!(i_cfg.enable && i_cfg.reset_en)) begin
      rst_reg <= 1'b0;
      cnt_reg <= '0;
    end else if (fall) begin
      rst_reg <= 1'b1; // R4
      cnt_reg <= CNT_W'(REL_DELAY_CYC);
    end else if (rst_reg) begin
      if (!level_reg && !i_cfg.release_from_drop) begin
        cnt_reg <= CNT_W'(REL_DELAY_CYC);
      end else if (cnt_reg == '0) begin
        rst_reg <= 1'b0; // R4
      end else begin
        cnt_reg <= cnt_reg - CNT_W'(1);
      end
    end
  end

  assign o_stat.level_flag    = level_reg;
  assign o_stat.crossing_flag = cross_reg;
  assign o_stat.irq_maskable  = irq_reg && !i_cfg.irq_nmi; // R5
  assign o_stat.irq_nmi       = irq_reg && i_cfg.irq_nmi;
  assign o_stat.event_pulse   = event_reg;
  assign o_stat.reset_req     = rst_reg;
endmodule
`default_nettype wire

//--- hdl/rvm_top.sv
// Reset source collection, voltage monitor channels and boot mode capture.
// Assumes analog comparators, reset pin and oscillator arrive asynchronously;
// watchdog and software requests are pulses on i_clk.
`timescale 1ns/1ps
`default_nettype none
module rvm_top (
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  input  wire logic                  i_ext_reset_pin_n,
  input  wire logic                  i_por_above,
  input  wire logic                  i_mon0_above,
  input  wire logic                  i_mon1_above,
  input  wire logic                  i_mon2_above,
  input  wire logic                  i_low_speed_oscillator,
  input  wire logic [1:0]            i_mode_pins,
  input  wire logic                  i_mode_usb,
  input  wire logic                  i_independent_watchdog_underflow,
  input  wire logic                  i_independent_watchdog_window_err,
  input  wire logic                  i_wdt_underflow,
  input  wire logic                  i_wdt_refresh_err,
  input  wire logic                  i_dsb_wake_irq,
  input  wire logic                  i_sw_reset,
  input  wire logic                  i_mon0_enable,
  input  wire logic [1:0]            i_monitor0_level_select,
  input  wire rvm_pkg::rvm_chan_cfg_s i_mon1_cfg,
  input  wire rvm_pkg::rvm_chan_cfg_s i_mon2_cfg,
  input  wire logic                  i_clr_cross1,
  input  wire logic                  i_clr_cross2,
  input  wire logic                  i_clr_cause,
  input  wire logic                  i_op_mode_we,
  input  wire rvm_pkg::rvm_op_e      i_op_mode,
  output logic                       o_chip_reset_n,
  output rvm_pkg::rvm_boot_e         o_boot_mode,
  output rvm_pkg::rvm_op_e           o_op_mode,
  output logic [1:0]                 o_mon0_level,
  output logic [3:0]                 o_mon1_level,
  output logic [3:0]                 o_mon2_level,
  output rvm_pkg::rvm_chan_stat_s    o_mon1_stat,
  output rvm_pkg::rvm_chan_stat_s    o_mon2_stat,
  output logic [rvm_pkg::CAUSE_W-1:0] o_reset_cause
);
  import rvm_pkg::*;

  // --------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------
  logic [1:0] s_pin, s_por, s_m0, s_m1, s_m2, s_ls, s_md0, s_md1, s_usb;
  logic       ls_prev_reg;
  logic       ls_tick;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_pin <= SYNC_RESET;
      s_por <= SYNC_RESET;
      s_m0  <= 2'h3;
      s_m1  <= 2'h3;
      s_m2  <= 2'h3;
      s_ls  <= SYNC_RESET;
      s_md0 <= SYNC_RESET;
      s_md1 <= SYNC_RESET;
      s_usb <= SYNC_RESET;
    end else begin
      s_pin <= {s_pin[0], i_ext_reset_pin_n};
      s_por <= {s_por[0], i_por_above};
      s_m0  <= {s_m0[0], i_mon0_above};
      s_m1  <= {s_m1[0], i_mon1_above};
      s_m2  <= {s_m2[0], i_mon2_above};
      s_ls  <= {s_ls[0], i_low_speed_oscillator};
      s_md0 <= {s_md0[0], i_mode_pins[0]};
      s_md1 <= {s_md1[0], i_mode_pins[1]};
      s_usb <= {s_usb[0], i_mode_usb};
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ls_prev_reg <= 1'b0;
    end else begin
      ls_prev_reg <= s_ls[1];
    end
  end
  assign ls_tick = s_ls[1] && !ls_prev_reg;

  // --------------------------------------------------------------
  // Level selects, clamped to the valid codes
  // --------------------------------------------------------------
  function automatic logic [3:0] clamp_lvl(input logic [3:0] v);
    clamp_lvl = (v > LVL_MAX) ? LVL_MAX : v;
  endfunction

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mon0_level <= 2'h0;
      o_mon1_level <= LVL_RESET;
      o_mon2_level <= LVL_RESET;
    end else begin
      o_mon0_level <= (i_monitor0_level_select > LVL0_MAX) ? LVL0_MAX
                                                           : i_monitor0_level_select; // R9
      o_mon1_level <= clamp_lvl(i_mon1_cfg.level_sel); // R8
      o_mon2_level <= clamp_lvl(i_mon2_cfg.level_sel); // R8
    end
  end

  // --------------------------------------------------------------
  // Monitor channels 1 and 2
  // --------------------------------------------------------------
  rvm_channel u_mon1 (
    .i_clk          (i_clk),
    .i_resetn       (i_resetn),
    .i_cmp_above    (s_m1[1]),
    .i_lsclk_tick   (ls_tick),
    .i_clr_crossing (i_clr_cross1),
    .i_cfg          (i_mon1_cfg),
    .o_stat         (o_mon1_stat)
  );

  rvm_channel u_mon2 (
    .i_clk          (i_clk),
    .i_resetn       (i_resetn),
    .i_cmp_above    (s_m2[1]),
    .i_lsclk_tick   (ls_tick),
    .i_clr_crossing (i_clr_cross2),
    .i_cfg          (i_mon2_cfg),
    .o_stat         (o_mon2_stat)
  );

  // --------------------------------------------------------------
  // Monitor 0 and power-on: hold while low, then fixed release delay
  // --------------------------------------------------------------
  logic [CNT_W-1:0] m0_cnt_reg;
  logic             m0_rst_reg;
  logic [CNT_W-1:0] por_cnt_reg;
  logic             por_rst_reg;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      m0_rst_reg <= 1'b0;
      m0_cnt_reg <= '0;
    end else if (!i_mon0_enable) begin
      m0_rst_reg <= 1'b0;
      m0_cnt_reg <= '0;
    end else if (!s_m0[1]) begin
      m0_rst_reg <= 1'b1; // R3
      m0_cnt_reg <= CNT_W'(REL_DELAY_CYC);
    end else if (m0_cnt_reg != '0) begin
      m0_cnt_reg <= m0_cnt_reg - CNT_W'(1);
    end else begin
      m0_rst_reg <= 1'b0; // R3
    end
  end

  // Comes up in reset so the chip waits for the supply after power-up
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      por_rst_reg <= 1'b1;
      por_cnt_reg <= CNT_W'(REL_DELAY_CYC);
    end else if (!s_por[1]) begin
      por_rst_reg <= 1'b1; // R2
      por_cnt_reg <= CNT_W'(REL_DELAY_CYC);
    end else if (por_cnt_reg != '0) begin
      por_cnt_reg <= por_cnt_reg - CNT_W'(1);
    end else begin
      por_rst_reg <= 1'b0; // R2
    end
  end

  // --------------------------------------------------------------
  // Reset combination and cause capture
  // --------------------------------------------------------------
  logic [CAUSE_W-1:0] src;
  logic               pulse_rst_reg;
  logic               chip_rst;
  logic               chip_rst_prev_reg;

  // Pulse sources hold reset for one cycle beyond the request
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pulse_rst_reg <= 1'b0;
    end else begin
      pulse_rst_reg <= i_independent_watchdog_underflow || i_independent_watchdog_window_err || i_wdt_underflow ||
                       i_wdt_refresh_err || i_dsb_wake_irq || i_sw_reset;
    end
  end

  always_comb begin
    src         = '0;
    src[C_PIN]  = !s_pin[1]; // R1
    src[C_POR]  = por_rst_reg;
    src[C_MON0] = m0_rst_reg;
    src[C_MON1] = o_mon1_stat.reset_req;
    src[C_MON2] = o_mon2_stat.reset_req;
    src[C_IWD]  = i_independent_watchdog_underflow || i_independent_watchdog_window_err; // R11
    src[C_WD]   = i_wdt_underflow || i_wdt_refresh_err; // R12
    src[C_DSB]  = i_dsb_wake_irq; // R13
    src[C_SW]   = i_sw_reset;
  end

  assign chip_rst = (|src) || pulse_rst_reg; // R17

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_chip_reset_n    <= 1'b0;
      chip_rst_prev_reg <= 1'b1;
    end else begin
      o_chip_reset_n    <= !chip_rst; // R17
      chip_rst_prev_reg <= chip_rst;
    end
  end

  // Cause flags live on i_resetn only, so chip reset does not clear them
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reset_cause <= '0;
    end else if (|src) begin
      o_reset_cause <= src; // R16
    end else if (i_clr_cause) begin
      o_reset_cause <= '0;
    end
  end

  // --------------------------------------------------------------
  // Boot and operating mode
  // --------------------------------------------------------------
  logic release_edge;
  assign release_edge = chip_rst_prev_reg && !chip_rst;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_boot_mode <= RVM_BOOT_SINGLE;
    end else if (release_edge) begin
      case ({s_md1[1], s_md0[1]}) // R14
        2'h3: o_boot_mode <= RVM_BOOT_SINGLE;
        2'h2: o_boot_mode <= RVM_BOOT_USER;
        2'h1: o_boot_mode <= RVM_BOOT_WIRE;
        default: o_boot_mode <= s_usb[1] ? RVM_BOOT_USB : RVM_BOOT_SERIAL;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_op_mode <= RVM_OP_SINGLE;
    end else if (release_edge) begin
      o_op_mode <= ({s_md1[1], s_md0[1]} == 2'h2) ? RVM_OP_USER : RVM_OP_SINGLE;
    end else if (i_op_mode_we && o_chip_reset_n) begin
      o_op_mode <= i_op_mode; // R15
    end
  end
endmodule
`default_nettype wire

//--- inc/rvm_pkg.sv
// Constants, types and encodings for the reset and voltage monitor block.
// Assumes a single 200 MHz clock and comparator/pin inputs that are asynchronous.
// Summary of operation
// R1 - Low reset pin forces chip reset
// R2 - Power-on comparator low produces power-on reset
// R3 - Monitor 0: reset below, delayed release
// R4 - Monitors 1/2 reset, selectable release timing
// R5 - Crossing interrupt: fall/rise/both, maskable or not
// R6 - Optional filter sampling at low-speed clock/n x2
// R7 - Live level flag and sticky crossing flag
// R8 - Monitors 1/2 use 4-bit five-level select
// R9 - Monitor 0 uses 2-bit two-level select
// R10 - Crossing pulses event-link output
// R11 - Independent watchdog underflow/window error resets
// R12 - Main watchdog underflow/refresh error resets
// R13 - Deep-standby wake interrupt produces reset
// R14 - Mode pins sampled at reset release
// R15 - Software may switch operating mode later
// R16 - Last reset cause kept across reset
// R17 - Any source holds reset until released
`default_nettype none
package rvm_pkg;
  localparam int unsigned CLK_HZ          = 200_000_000;
  // Release delay after supply recovers, in microseconds
  localparam int unsigned REL_DELAY_US    = 100;
  localparam int unsigned REL_DELAY_CYC   = REL_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CNT_W           = 24;
  localparam logic [1:0]  SYNC_RESET      = 2'h0;
  localparam logic [3:0]  LVL_MAX         = 4'h4;    // Five valid levels 0..4
  localparam logic [1:0]  LVL0_MAX        = 2'h1;    // Two valid levels 0..1
  localparam logic [3:0]  LVL_RESET       = 4'h0;
  localparam logic [4:0]  DIV_RESET       = 5'h00;
  localparam int unsigned CAUSE_W         = 9;
  // Cause bit positions
  localparam int unsigned C_PIN  = 0;
  localparam int unsigned C_POR  = 1;
  localparam int unsigned C_MON0 = 2;
  localparam int unsigned C_MON1 = 3;
  localparam int unsigned C_MON2 = 4;
  localparam int unsigned C_IWD  = 5;
  localparam int unsigned C_WD   = 6;
  localparam int unsigned C_DSB  = 7;
  localparam int unsigned C_SW   = 8;

  typedef enum logic [1:0] {
    RVM_IRQ_FALL = 2'h0,
    RVM_IRQ_RISE = 2'h1,
    RVM_IRQ_BOTH = 2'h2
  } rvm_irq_edge_e;

  typedef enum logic [1:0] {
    RVM_DIV2 = 2'h0, RVM_DIV4 = 2'h1, RVM_DIV8 = 2'h2, RVM_DIV16 = 2'h3
  } rvm_div_e;

  typedef enum logic [2:0] {
    RVM_BOOT_SINGLE = 3'h0,
    RVM_BOOT_SERIAL = 3'h1,
    RVM_BOOT_USB    = 3'h2,
    RVM_BOOT_WIRE   = 3'h3,
    RVM_BOOT_USER   = 3'h4
  } rvm_boot_e;

  typedef enum logic [1:0] {
    RVM_OP_SINGLE = 2'h0,
    RVM_OP_USER   = 2'h1,
    RVM_OP_EXT_NOROM = 2'h2,
    RVM_OP_EXT_ROM   = 2'h3
  } rvm_op_e;

  // Per-channel configuration for monitors 1 and 2
  typedef struct packed {
    logic          enable;
    logic          reset_en;
    logic          release_from_drop;  // 1: delay counted from the drop
    logic          filter_en;
    rvm_div_e      filter_div;
    rvm_irq_edge_e irq_edge;
    logic          irq_en;
    logic          irq_nmi;
    logic [3:0]    level_sel;
  } rvm_chan_cfg_s;

  typedef struct packed {
    logic level_flag;     // 1: supply above threshold
    logic crossing_flag;
    logic irq_maskable;
    logic irq_nmi;
    logic event_pulse;
    logic reset_req;
  } rvm_chan_stat_s;
endpackage
`default_nettype wire

//--- sim/rvm_partner.sv
// Far side of the block: supply comparators, reset pin, low-speed oscillator.
// Assumes the bench calls drive() from its own sequence.
`timescale 1ns/1ps
`default_nettype none
module rvm_partner (
  input  wire logic   i_clk,
  output logic        o_lso,
  output logic [3:0]  o_above,
  output logic        o_pin_n
);
  // Runs free and unrelated to i_clk, 200 ns period
  initial begin
    o_lso = 1'b0;
    forever #100 o_lso = ~o_lso;
  end
  initial begin
    o_above = 4'h0;
    o_pin_n = 1'b1;
  end
  // Bit 0 power-on, bits 1..3 monitors 0..2; 1 means supply above threshold
  task automatic drive(input logic [3:0] above, input logic pin_n);
    @(negedge i_clk);
    o_above = above;
    o_pin_n = pin_n;
  endtask
endmodule
`default_nettype wire

//--- sim/rvm_top_bench.sv
// Self-checking bench for rvm_top with the comparator and pin model.
// Assumes the 20000-cycle release delay; four long releases stay under 100k cycles.
`timescale 1ns/1ps
`default_nettype none
module rvm_top_bench;
  import rvm_pkg::*;
  logic i_clk, i_resetn, i_mon0_enable, i_mode_usb, i_clr_cross1, i_clr_cross2;
  logic i_clr_cause, i_op_mode_we, o_chip_reset_n, lso, pin_n;
  logic [1:0] i_mode_pins, i_monitor0_level_select, o_mon0_level;
  logic [3:0] above, o_mon1_level, o_mon2_level;
  logic [5:0] pulse;
  logic [CAUSE_W-1:0] o_reset_cause;
  rvm_chan_cfg_s i_mon1_cfg, i_mon2_cfg;
  rvm_chan_stat_s o_mon1_stat, o_mon2_stat;
  rvm_op_e i_op_mode, o_op_mode;
  rvm_boot_e o_boot_mode;
  int errors = 0, cmp_count = 0, n_ev = 0, n_irq = 0, n_nmi = 0, n, t, b_ev, b_irq, b_nmi;
  int unsigned cbit[6] = '{C_IWD, C_IWD, C_WD, C_WD, C_DSB, C_SW};

  rvm_partner p (.i_clk, .o_lso(lso), .o_above(above), .o_pin_n(pin_n));
  rvm_top uut (.i_clk, .i_resetn, .i_ext_reset_pin_n(pin_n), .i_por_above(above[0]),
    .i_mon0_above(above[1]), .i_mon1_above(above[2]), .i_mon2_above(above[3]),
    .i_low_speed_oscillator(lso), .i_mode_pins, .i_mode_usb, .i_independent_watchdog_underflow(pulse[0]),
    .i_independent_watchdog_window_err(pulse[1]), .i_wdt_underflow(pulse[2]), .i_wdt_refresh_err(pulse[3]),
    .i_dsb_wake_irq(pulse[4]), .i_sw_reset(pulse[5]), .i_mon0_enable,
    .i_monitor0_level_select, .i_mon1_cfg, .i_mon2_cfg, .i_clr_cross1, .i_clr_cross2,
    .i_clr_cause, .i_op_mode_we, .i_op_mode, .o_chip_reset_n, .o_boot_mode, .o_op_mode,
    .o_mon0_level, .o_mon1_level, .o_mon2_level, .o_mon1_stat, .o_mon2_stat, .o_reset_cause);

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    if (o_mon1_stat.event_pulse === 1'b1) n_ev++;
    if (o_mon1_stat.irq_maskable === 1'b1) n_irq++;
    if (o_mon1_stat.irq_nmi === 1'b1) n_nmi++;
  end

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic report_and_stop();
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge i_clk);
  endtask
  // Bounded wait for the chip reset output to reach a level
  task automatic wait_rst(input logic lvl, input int bound, output int cnt);
    cnt = 0;
    while (o_chip_reset_n !== lvl) begin
      cyc(1);
      cnt++;
      if (cnt > bound) begin
        errors++;
        report_and_stop();
      end
    end
  endtask
  function automatic logic [3:0] clamp(input logic [3:0] v, input logic [3:0] m);
    return (v > m) ? m : v;
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(54));
    {i_clr_cross1, i_clr_cross2, i_clr_cause, i_op_mode_we, pulse, i_mode_pins} = '0;
    {i_mon0_enable, i_mode_usb, i_monitor0_level_select} = 4'hf;
    i_op_mode = RVM_OP_SINGLE;
    i_mon1_cfg = '0;
    i_mon1_cfg.enable = 1'b1;
    i_mon1_cfg.irq_en = 1'b1;
    i_mon2_cfg = i_mon1_cfg;
    i_resetn = 1'b0;
    cyc(16);
    i_resetn = 1'b1;
    cyc(2);
    chk("chip_reset_n", o_chip_reset_n, 0);
    p.drive(4'hf, 1'b1);
    wait_rst(1'b1, REL_DELAY_CYC + 100, n);
    chk("por_delay", n >= REL_DELAY_CYC, 1);
    chk("boot", o_boot_mode, RVM_BOOT_USB);
    chk("cause_por", o_reset_cause[C_POR], 1);
    for (int k = 0; k < 4; k++) begin
      i_op_mode = rvm_op_e'(k);
      i_op_mode_we = 1'b1;
      cyc(1);
      i_op_mode_we = 1'b0;
      cyc(1);
      chk("op_mode", o_op_mode, k);
    end
    repeat (8) begin
      i_mon1_cfg.level_sel = $urandom;
      i_mon2_cfg.level_sel = $urandom;
      i_monitor0_level_select = $urandom;
      cyc(3);
      chk("level1", o_mon1_level, clamp(i_mon1_cfg.level_sel, LVL_MAX));
      chk("level2", o_mon2_level, clamp(i_mon2_cfg.level_sel, LVL_MAX));
      chk("level0", o_mon0_level, clamp({2'h0, i_monitor0_level_select}, 4'h1));
    end
    for (int e = 0; e < 3; e++) begin
      i_mon1_cfg.irq_edge = rvm_irq_edge_e'(e);
      i_mon1_cfg.irq_nmi = $urandom;
      {b_ev, b_irq, b_nmi} = {n_ev, n_irq, n_nmi};
      p.drive(4'hb, 1'b1);
      cyc(10);
      chk("level_flag1", o_mon1_stat.level_flag, 0);
      chk("crossing1", o_mon1_stat.crossing_flag, 1);
      p.drive(4'hf, 1'b1);
      cyc(10);
      chk("level_flag1", o_mon1_stat.level_flag, 1);
      chk("events1", n_ev - b_ev, 2);
      chk("irqs1", n_irq + n_nmi - b_irq - b_nmi, (e == 2) ? 2 : 1);
      chk("nmi1", (n_nmi - b_nmi) != 0, i_mon1_cfg.irq_nmi);
      i_clr_cross1 = 1'b1;
      cyc(1);
      i_clr_cross1 = 1'b0;
      cyc(1);
      chk("crossing1", o_mon1_stat.crossing_flag, 0);
    end
    // Short glitch must fall between filter samples, a long drop must pass
    i_mon2_cfg.filter_en = 1'b1;
    i_mon2_cfg.filter_div = rvm_div_e'($urandom_range(1, 0));
    p.drive(4'h7, 1'b1);
    cyc(8);
    p.drive(4'hf, 1'b1);
    cyc(1000);
    chk("level_flag2", o_mon2_stat.level_flag, 1);
    p.drive(4'h7, 1'b1);
    cyc(1000);
    chk("level_flag2", o_mon2_stat.level_flag, 0);
    p.drive(4'hf, 1'b1);
    cyc(1000);
    for (int k = 0; k < 6; k++) begin
      pulse[k] = 1'b1;
      cyc(1);
      pulse = '0;
      wait_rst(1'b0, 4, n);
      wait_rst(1'b1, 40, n);
      chk("cause_pulse", o_reset_cause, 9'h1 << cbit[k]);
    end
    p.drive(4'hd, 1'b1);
    wait_rst(1'b0, 8, n);
    chk("cause_mon0", o_reset_cause[C_MON0], 1);
    cyc(50);
    p.drive(4'hf, 1'b1);
    wait_rst(1'b1, REL_DELAY_CYC + 100, n);
    chk("mon0_delay", n >= REL_DELAY_CYC && n <= REL_DELAY_CYC + 10, 1);
    // Delay timed from recovery first, then timed from the drop
    for (int m = 0; m < 2; m++) begin
      i_mon1_cfg.reset_en = 1'b1;
      i_mon1_cfg.release_from_drop = m[0];
      p.drive(4'hb, 1'b1);
      wait_rst(1'b0, 8, t);
      cyc(100);
      p.drive(4'hf, 1'b1);
      wait_rst(1'b1, REL_DELAY_CYC + 100, n);
      t = m ? t + n + 101 : n;
      chk("mon1_delay", t >= REL_DELAY_CYC && t <= REL_DELAY_CYC + 10, 1);
    end
    i_mon1_cfg.reset_en = 1'b0;
    i_mode_pins = 2'h2;
    p.drive(4'hf, 1'b0);
    wait_rst(1'b0, 8, n);
    chk("cause_pin", o_reset_cause[C_PIN], 1);
    cyc(20);
    i_op_mode = RVM_OP_EXT_ROM;
    i_op_mode_we = 1'b1;
    cyc(1);
    i_op_mode_we = 1'b0;
    p.drive(4'hf, 1'b1);
    wait_rst(1'b1, REL_DELAY_CYC + 100, n);
    chk("boot", o_boot_mode, RVM_BOOT_USER);
    chk("op_mode", o_op_mode, RVM_OP_USER);
    report_and_stop();
  end
endmodule
`default_nettype wire

//--- sim/rvm_top_properties.sv
// Checker for rvm_top: reset sources, level clamps, mode writes, monitor 1 flags.
// Assumes one clock domain and an async active-low i_resetn; bound into rvm_top.
`timescale 1ns/1ps
`default_nettype none
module rvm_top_properties
  import rvm_pkg::*;
(
  input wire logic                i_clk,
  input wire logic                i_resetn,
  input wire logic                i_ext_reset_pin_n,
  input wire logic                i_por_above,
  input wire logic                i_mon0_above,
  input wire logic                i_mon0_enable,
  input wire logic                i_independent_watchdog_underflow,
  input wire logic                i_wdt_underflow,
  input wire logic                i_wdt_refresh_err,
  input wire logic                i_dsb_wake_irq,
  input wire logic [1:0]          i_monitor0_level_select,
  input wire rvm_chan_cfg_s       i_mon1_cfg,
  input wire logic                i_op_mode_we,
  input wire rvm_op_e             i_op_mode,
  input wire logic                o_chip_reset_n,
  input wire rvm_op_e             o_op_mode,
  input wire logic [1:0]          o_mon0_level,
  input wire logic [3:0]          o_mon1_level,
  input wire rvm_chan_stat_s      o_mon1_stat,
  input wire logic [CAUSE_W-1:0]  o_reset_cause
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  a_pin_holds_reset:
    assert property (!i_ext_reset_pin_n [*5] |-> !o_chip_reset_n) else $error("pin low, no reset");
  a_por_holds_reset:
    assert property (!i_por_above [*5] |-> !o_chip_reset_n) else $error("por low, no reset");
  a_mon0_holds_reset:
    assert property ((i_mon0_enable && !i_mon0_above) [*5] |-> !o_chip_reset_n)
      else $error("monitor 0 low, no reset");
  a_independent_watchdog_resets:
    assert property (i_independent_watchdog_underflow |-> ##[1:3] !o_chip_reset_n) else $error("independent_watchdog no reset");
  a_wdt_cause:
    assert property ((i_wdt_underflow || i_wdt_refresh_err) |-> ##[1:3] o_reset_cause[C_WD])
      else $error("wdt cause missing");
  a_dsb_cause:
    assert property (i_dsb_wake_irq |-> ##[1:3] o_reset_cause[C_DSB]) else $error("dsb cause missing");
  a_cause_on_reset:
    assert property ($fell(o_chip_reset_n) |-> o_reset_cause != '0) else $error("reset, no cause");
  a_event_single:
    assert property (o_mon1_stat.event_pulse |-> o_mon1_stat.crossing_flag
      ##1 !o_mon1_stat.event_pulse) else $error("event pulse wrong");
  a_irq_route:
    assert property ((o_mon1_stat.irq_maskable || o_mon1_stat.irq_nmi) |->
      o_mon1_stat.event_pulse && (o_mon1_stat.irq_nmi == i_mon1_cfg.irq_nmi))
      else $error("irq routing wrong");
  a_level1_clamp:
    assert property ($stable(i_mon1_cfg.level_sel) && $past(i_resetn) |-> o_mon1_level ==
      ((i_mon1_cfg.level_sel > LVL_MAX) ? LVL_MAX : i_mon1_cfg.level_sel))
      else $error("level 1 clamp wrong");
  a_level0_clamp:
    assert property ($stable(i_monitor0_level_select) && $past(i_resetn) |-> o_mon0_level ==
      ((i_monitor0_level_select > LVL0_MAX) ? LVL0_MAX : i_monitor0_level_select))
      else $error("level 0 clamp wrong");
  a_op_write:
    assert property (i_op_mode_we && o_chip_reset_n |=> o_op_mode == $past(i_op_mode))
      else $error("op mode write lost");
endmodule

bind rvm_top rvm_top_properties u_props (.i_clk, .i_resetn, .i_ext_reset_pin_n, .i_por_above,
  .i_mon0_above, .i_mon0_enable, .i_independent_watchdog_underflow, .i_wdt_underflow, .i_wdt_refresh_err,
  .i_dsb_wake_irq, .i_monitor0_level_select, .i_mon1_cfg, .i_op_mode_we, .i_op_mode,
  .o_chip_reset_n, .o_op_mode, .o_mon0_level, .o_mon1_level, .o_mon1_stat, .o_reset_cause);
`default_nettype wire
